// *** common/ris_pkg.sv ***
package ris_pkg;
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_TRAP = 16'hFFFC;
	localparam logic [15:0] VEC_USB_WAKE = 16'hFFFA;
	localparam logic [15:0] VEC_PIN = 16'hFFF8;
	localparam logic [15:0] VEC_TIMER = 16'hFFF6;
	localparam logic [15:0] VEC_I2C = 16'hFFF4;
	localparam logic [15:0] VEC_SERIAL = 16'hFFF2;
	localparam logic [15:0] VEC_USB_PERIPH = 16'hFFF0;
	localparam logic [15:0] SP_TOP = 16'h013F;
	localparam logic [15:0] TIMER_PRESET = 16'hFFFC;
	localparam int START_CYCLES = 4096;
	localparam logic [7:0] ADDR_EDGE_EN = 8'h08;
	localparam logic [7:0] ADDR_MISC = 8'h09;
	localparam logic [7:0] ADDR_PENDING = 8'h0A;
	localparam logic [7:0] ADDR_STATE = 8'h0B;
	localparam int MISC_DET_DIS = 0;
	localparam logic [7:0] EDGE_EN_RST = 8'h00;
	localparam logic [7:0] RISE_LINES = 8'h33;
	localparam int NPER = 4;
	typedef enum {RIS_RESET, RIS_START, RIS_RUN, RIS_WAIT, RIS_HALT} ris_state_t;
	typedef struct packed {
		logic [15:0] vector;
		logic take;
		logic [2:0] source;
	} ris_entry_t;
	typedef struct packed {
		logic coreReset;
		logic periphReset;
		logic oscRun;
		logic timerClkEn;
	} ris_ctl_t;
endpackage

// *** hw/ris_sequencer.sv ***
`timescale 1ns/100ps
module ris_sequencer
	import ris_pkg::*;
#(
	parameter int START_DELAY = START_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic lowSupply,
	input wire logic watchdogReset,
	input wire logic extResetPinIn_n,
	output logic resetPinOut,
	output logic resetPinOe,
	input wire logic [7:0] externalPinIrqLine,
	input wire logic [NPER-1:0] periphFlag,
	input wire logic [NPER-1:0] periphEnable,
	input wire logic [NPER-1:0] periphClear,
	input wire logic usbWakeFlag,
	input wire logic usbWakeClear,
	input wire logic instrBoundary,
	input wire logic trapInstr,
	input wire logic returnFromIsrInstr,
	input wire logic waitInstr,
	input wire logic haltInstr,
	input wire logic [15:0] programCounter,
	input wire logic [7:0] xIndex,
	input wire logic [7:0] accumulator,
	input wire logic [7:0] conditionFlags,
	output ris_entry_t entry,
	output logic [15:0] stackPointer,
	output logic [7:0] pushByte,
	output logic pushValid,
	output logic popStrobe,
	output logic irqMask,
	output ris_ctl_t ctl,
	output logic [15:0] timerPreset,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata
);
	localparam logic [12:0] DELAY_LAST = 13'(START_DELAY - 1);
	localparam logic [2:0] PUSH_BYTES = 3'h5;
	ris_state_t state_r, state_nxt;
	logic [12:0] count_r;
	logic [7:0] edgeEn_r, misc_r, pinPrev_r, pinPend_r;
	logic [NPER-1:0] perPend_r;
	logic usbPend_r, mask_r, trapPend_r, haltExit_r;
	logic [39:0] pushBuf_r;
	logic [2:0] pushCnt_r;
	logic [15:0] sp_r;
	logic [7:0] rdata_r;
	ris_entry_t entry_r;
	// Low supply gated by the disable bit
	wire lowActive = lowSupply & ~misc_r[MISC_DET_DIS];
	// Any source restarts the whole sequence; external pin assumed held long enough
	wire anyReset = ~reset_n | lowActive | watchdogReset | ~extResetPinIn_n;
	wire [7:0] pinEdge = (externalPinIrqLine & ~pinPrev_r & RISE_LINES)
		| (~externalPinIrqLine & pinPrev_r & ~RISE_LINES);
	wire [NPER-1:0] perReq = perPend_r & periphEnable & {NPER{~mask_r}};
	wire pinReq = |pinPend_r & ~mask_r;
	wire usbReq = usbPend_r & ~mask_r;
	wire haltWake = |(pinPend_r & edgeEn_r) | usbPend_r;
	wire anyReq = usbReq | pinReq | (|perReq);
	wire inRun = state_r == RIS_RUN;
	wire takeNow = inRun & instrBoundary & (trapPend_r | anyReq) & pushCnt_r == 3'h0;
	wire selWrite = regWrite & clkEn;
	// Fixed priority chain, highest first
	logic [15:0] vecSel;
	always_comb begin
		vecSel = VEC_USB_PERIPH;
		if (trapPend_r) vecSel = VEC_TRAP;
		else if (usbReq) vecSel = VEC_USB_WAKE;
		else if (pinReq) vecSel = VEC_PIN;
		else if (perReq[0]) vecSel = VEC_TIMER;
		else if (perReq[1]) vecSel = VEC_I2C;
		else if (perReq[2]) vecSel = VEC_SERIAL;
	end
	logic [2:0] srcSel;
	always_comb begin
		srcSel = 3'h7;
		if (trapPend_r) srcSel = 3'h1;
		else if (usbReq) srcSel = 3'h2;
		else if (pinReq) srcSel = 3'h3;
		else if (perReq[0]) srcSel = 3'h4;
		else if (perReq[1]) srcSel = 3'h5;
		else if (perReq[2]) srcSel = 3'h6;
	end
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RIS_RESET: state_nxt = RIS_START;
			RIS_START: if (count_r == DELAY_LAST) state_nxt = RIS_RUN;
			RIS_RUN: begin
				if (haltInstr) state_nxt = RIS_HALT;
				else if (waitInstr) state_nxt = RIS_WAIT;
			end
			RIS_WAIT: if (usbPend_r | (|pinPend_r) | (|(perPend_r & periphEnable)))
				state_nxt = RIS_RUN;
			RIS_HALT: if (haltWake) state_nxt = RIS_START;
			default: state_nxt = RIS_RESET;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			state_r <= RIS_RESET;
			count_r <= '0;
			haltExit_r <= 1'b0;
		end else if (clkEn) begin
			state_r <= state_nxt;
			count_r <= (state_r == RIS_START) ? count_r + 13'h1 : '0;
			if (state_r == RIS_HALT) haltExit_r <= 1'b1;
			else if (state_nxt == RIS_RUN) haltExit_r <= 1'b0;
		end
	end
	// Mask: set by reset and entry, cleared by low-power entry and return
	always_ff @(posedge sys_clk) begin
		if (anyReset) mask_r <= 1'b1;
		else if (clkEn) begin
			if (takeNow) mask_r <= 1'b1;
			else if (inRun & (waitInstr | haltInstr)) mask_r <= 1'b0;
			else if (returnFromIsrInstr) mask_r <= 1'b0;
			else if (inRun & instrBoundary) mask_r <= conditionFlags[3];
		end
	end
	// Request latches; a new edge wins over a same-cycle clear
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			// Track the live level so a line already high gives no false edge
			pinPrev_r <= externalPinIrqLine;
			pinPend_r <= '0;
			perPend_r <= '0;
			usbPend_r <= 1'b0;
			trapPend_r <= 1'b0;
		end else if (clkEn) begin
			pinPrev_r <= externalPinIrqLine;
			pinPend_r <= (pinPend_r & ~{8{takeNow & srcSel == 3'h3}}) | (pinEdge & edgeEn_r);
			perPend_r <= (perPend_r & ~periphClear) | periphFlag;
			usbPend_r <= (usbPend_r & ~usbWakeClear) | usbWakeFlag;
			trapPend_r <= (trapPend_r & ~(takeNow & srcSel == 3'h1)) | (trapInstr & inRun);
		end
	end
	// Context push, low byte of program counter first
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			sp_r <= SP_TOP;
			pushCnt_r <= '0;
			pushBuf_r <= '0;
			entry_r <= '{vector: VEC_RESET, take: 1'b1, source: 3'h0};
		end else if (clkEn) begin
			entry_r.take <= state_r == RIS_START && count_r == DELAY_LAST && !haltExit_r;
			entry_r.vector <= VEC_RESET;
			entry_r.source <= 3'h0;
			if (takeNow) begin
				entry_r <= '{vector: vecSel, take: 1'b1, source: srcSel};
				pushBuf_r <= {conditionFlags, accumulator, xIndex, programCounter[15:8],
					programCounter[7:0]};
				pushCnt_r <= PUSH_BYTES;
			end else if (pushCnt_r != 3'h0) begin
				pushBuf_r <= {8'h00, pushBuf_r[39:8]};
				pushCnt_r <= pushCnt_r - 3'h1;
				sp_r <= sp_r - 16'h1;
			end else if (returnFromIsrInstr) begin
				sp_r <= sp_r + 16'(PUSH_BYTES);
			end
		end
	end
	// Register slave; edge enable steers pin latching, state readable
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			edgeEn_r <= EDGE_EN_RST;
			rdata_r <= '0;
		end else if (clkEn) begin
			if (selWrite && regAddr == ADDR_EDGE_EN) edgeEn_r <= regWdata;
			rdata_r <= '0;
			if (regRead) begin
				case (regAddr)
					ADDR_EDGE_EN: rdata_r <= edgeEn_r;
					ADDR_MISC: rdata_r <= misc_r;
					ADDR_PENDING: rdata_r <= pinPend_r;
					ADDR_STATE: rdata_r <= {3'h0, usbPend_r, mask_r, 3'(state_r)};
					default: rdata_r <= '0;
				endcase
			end
		end
	end
	// Misc survives the detector's own reset so the disable holds
	always_ff @(posedge sys_clk) begin
		if (!reset_n) misc_r <= '0;
		else if (clkEn && selWrite && regAddr == ADDR_MISC) misc_r <= regWdata;
	end
	assign resetPinOut = 1'b0;
	assign resetPinOe = lowActive | watchdogReset;
	assign entry = entry_r;
	assign stackPointer = sp_r;
	assign pushByte = pushBuf_r[7:0];
	assign pushValid = pushCnt_r != 3'h0;
	assign popStrobe = returnFromIsrInstr & inRun;
	assign irqMask = mask_r;
	assign regRdata = rdata_r;
	assign timerPreset = TIMER_PRESET;
	always_comb begin
		ctl.coreReset = state_r == RIS_RESET || state_r == RIS_START;
		ctl.periphReset = state_r == RIS_RESET && !haltExit_r;
		ctl.oscRun = !(state_r == RIS_HALT || state_r == RIS_RESET);
		ctl.timerClkEn = state_r == RIS_RUN || state_r == RIS_WAIT;
	end
endmodule

// *** sim/ris_sequencer_props.sv ***
`timescale 1ns/100ps
module ris_sequencer_props
	import ris_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic watchdogReset,
	input wire logic extResetPinIn_n,
	input wire logic resetPinOut,
	input wire logic resetPinOe,
	input wire ris_entry_t entry,
	input wire logic [15:0] stackPointer,
	input wire logic pushValid,
	input wire logic irqMask,
	input wire ris_ctl_t ctl
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence push_burst;
		pushValid [*5] ##1 !pushValid;
	endsequence
	vec_map_a: assert property (entry.take |-> entry.vector == VEC_RESET - {entry.source, 1'b0})
		else $error("vector does not match source");
	take_mask_a: assert property (entry.take |-> irqMask)
		else $error("mask clear on entry");
	push_len_a: assert property (entry.take && entry.source != 3'h0 |-> push_burst)
		else $error("context push not five bytes");
	sp_reset_a: assert property ($rose(reset_n) |-> stackPointer == SP_TOP && irqMask)
		else $error("reset state wrong");
	start_hold_a: assert property ($rose(reset_n) |-> ctl.coreReset [*8])
		else $error("core released early");
	src_reset_a: assert property (!extResetPinIn_n || watchdogReset |=> ctl.coreReset)
		else $error("reset source ignored");
	wdog_pin_a: assert property (watchdogReset |-> resetPinOe)
		else $error("pin not driven on watchdog");
	pin_low_a: assert property (resetPinOe |-> !resetPinOut)
		else $error("pin driven high");
endmodule
bind ris_sequencer ris_sequencer_props ris_sequencer_props_i (.*);

// *** sim/ris_core_model.sv ***
`timescale 1ns/100ps
module ris_core_model (
	input wire logic pushValid,
	input wire logic cfMask,
	output logic instrBoundary,
	output logic [15:0] programCounter,
	output logic [7:0] xIndex,
	output logic [7:0] accumulator,
	output logic [7:0] conditionFlags
);
	// No instruction ends while context goes out
	assign instrBoundary = !pushValid;
	assign programCounter = 16'h1234;
	assign xIndex = 8'h56;
	assign accumulator = 8'h78;
	assign conditionFlags = {4'hE, cfMask, 3'h0};
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
	import ris_pkg::*;
	logic sys_clk = '0, reset_n = '0, clkEn = '1, lowSupply = '0, watchdogReset = '0;
	logic extResetPinIn_n = '1, usbWakeFlag = '0, usbWakeClear = '0, trapInstr = '0;
	logic returnFromIsrInstr = '0, waitInstr = '0, haltInstr = '0, regWrite = '0;
	logic regRead = '0, cfMask = '1, resetPinOut, resetPinOe, pushValid, popStrobe;
	logic irqMask, instrBoundary;
	logic [7:0] externalPinIrqLine = 8'hCC, regAddr = '0, regWdata = '0, regRdata, pushByte;
	logic [NPER-1:0] periphFlag = '0, periphEnable = '0, periphClear = '0;
	logic [15:0] programCounter, stackPointer, timerPreset;
	logic [7:0] xIndex, accumulator, conditionFlags;
	ris_entry_t entry;
	ris_ctl_t ctl;
	int mismatches = 0, checked = 0;
	ris_sequencer #(.START_DELAY(8)) ris_sequencer_i (.*);
	ris_core_model ris_core_model_i (.*);
	always #5 sys_clk = ~sys_clk;
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task close_out;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 chk("regRdata", {8'h00, e}, {8'h00, regRdata});
	endtask
	task automatic wt(input logic [15:0] e);
		int i;
		i = 0;
		do begin
			@(posedge sys_clk);
			#1 i++;
		end while (entry.take !== 1'b1 && i < 80);
		if (i >= 80) begin
			mismatches++;
			close_out();
		end else chk("vector", e, entry.vector);
	endtask
	task automatic nt(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			#1 chk("take", 16'h0000, {15'h0000, entry.take});
		end
	endtask
	// Flag and clear pulses, one cycle each
	task automatic pf(input logic [3:0] f, input logic [3:0] c);
		@(posedge sys_clk);
		periphFlag <= f;
		periphClear <= c;
		@(posedge sys_clk);
		periphFlag <= 4'h0;
		periphClear <= 4'h0;
	endtask
	initial begin
		logic [7:0] q [5];
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		wt(VEC_RESET);
		chk("timerPreset", TIMER_PRESET, timerPreset);
		rd(ADDR_EDGE_EN, EDGE_EN_RST);
		rd(8'h3C, 8'h00);
		wr(ADDR_EDGE_EN, 8'h05);
		rd(ADDR_EDGE_EN, 8'h05);
		$display("test regs done");
		cfMask <= 1'b0;
		externalPinIrqLine <= 8'hCD;
		wt(VEC_PIN);
		q = '{8'h34, 8'h12, 8'h56, 8'h78, 8'hE0};
		for (int k = 0; k < 5; k++) begin
			chk("pushByte", {8'h00, q[k]}, {8'h00, pushByte});
			@(posedge sys_clk);
			#1;
		end
		chk("stackPointer", SP_TOP - 16'h0005, stackPointer);
		@(posedge sys_clk);
		returnFromIsrInstr <= 1'b1;
		#1 chk("popStrobe", 16'h0001, {15'h0000, popStrobe});
		@(posedge sys_clk);
		returnFromIsrInstr <= 1'b0;
		#1 chk("stackPointer", SP_TOP, stackPointer);
		externalPinIrqLine <= 8'hC9;
		wt(VEC_PIN);
		$display("test pins done");
		periphEnable <= 4'hF;
		pf(4'h9, 4'h0);
		wt(VEC_TIMER);
		pf(4'h0, 4'h1);
		wt(VEC_USB_PERIPH);
		pf(4'h0, 4'h8);
		cfMask <= 1'b1;
		pf(4'h2, 4'h0);
		nt(6);
		cfMask <= 1'b0;
		wt(VEC_I2C);
		pf(4'h0, 4'h2);
		periphEnable <= 4'hB;
		pf(4'h4, 4'h0);
		pf(4'h0, 4'h4);
		periphEnable <= 4'hF;
		nt(10);
		$display("test periph done");
		cfMask <= 1'b1;
		trapInstr <= 1'b1;
		@(posedge sys_clk);
		trapInstr <= 1'b0;
		wt(VEC_TRAP);
		cfMask <= 1'b0;
		usbWakeFlag <= 1'b1;
		@(posedge sys_clk);
		usbWakeFlag <= 1'b0;
		wt(VEC_USB_WAKE);
		usbWakeClear <= 1'b1;
		@(posedge sys_clk);
		usbWakeClear <= 1'b0;
		$display("test trap done");
		@(posedge sys_clk);
		cfMask <= 1'b1;
		waitInstr <= 1'b1;
		@(posedge sys_clk);
		waitInstr <= 1'b0;
		#1 chk("irqMask", 16'h0000, {15'h0000, irqMask});
		chk("timerClkEn", 16'h0001, {15'h0000, ctl.timerClkEn});
		cfMask <= 1'b0;
		usbWakeFlag <= 1'b1;
		@(posedge sys_clk);
		usbWakeFlag <= 1'b0;
		wt(VEC_USB_WAKE);
		usbWakeClear <= 1'b1;
		@(posedge sys_clk);
		usbWakeClear <= 1'b0;
		cfMask <= 1'b1;
		haltInstr <= 1'b1;
		externalPinIrqLine <= 8'hC8;
		@(posedge sys_clk);
		haltInstr <= 1'b0;
		#1 chk("irqMask", 16'h0000, {15'h0000, irqMask});
		chk("oscRun", 16'h0000, {15'h0000, ctl.oscRun});
		cfMask <= 1'b0;
		externalPinIrqLine <= 8'hC9;
		wt(VEC_PIN);
		$display("test low power done");
		wr(ADDR_MISC, 8'h01);
		lowSupply <= 1'b1;
		nt(4);
		chk("resetPinOe", 16'h0000, {15'h0000, resetPinOe});
		lowSupply <= 1'b0;
		watchdogReset <= 1'b1;
		@(posedge sys_clk);
		#1 chk("resetPinOe", 16'h0001, {15'h0000, resetPinOe});
		watchdogReset <= 1'b0;
		wt(VEC_RESET);
		extResetPinIn_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		extResetPinIn_n <= 1'b1;
		wt(VEC_RESET);
		wr(ADDR_MISC, 8'h00);
		lowSupply <= 1'b1;
		@(posedge sys_clk);
		#1 chk("resetPinOe", 16'h0001, {15'h0000, resetPinOe});
		lowSupply <= 1'b0;
		wt(VEC_RESET);
		rd(ADDR_EDGE_EN, EDGE_EN_RST);
		$display("test resets done");
		close_out();
	end
endmodule
